// ==== rtl/lslcr_pkg.sv ====
package lslcr_pkg;

    // management addressing
    localparam logic [4:0]  DEV_ADDR            = 5'h1E;
    localparam logic [15:0] OFS_LANE_DRIVER     = 16'h0007;
    localparam logic [15:0] OFS_LANE_POL_EQ     = 16'h0008;
    localparam logic [15:0] OFS_STATUS_OVERLAY  = 16'h0009;

    // reset values
    localparam logic [15:0] RST_LANE_DRIVER     = 16'hDC04;
    localparam logic [15:0] RST_LANE_POL_EQ     = 16'h000D;
    localparam logic [15:0] RST_STATUS_OVERLAY  = 16'h0380;

    // lane driver control field positions
    localparam int AMP_MSB      = 14;
    localparam int AMP_LSB      = 12;
    localparam int LOS_EN_BIT   = 11;
    localparam int TX_EN_BIT    = 10;
    localparam int TX_RATE_MSB  = 9;
    localparam int TX_RATE_LSB  = 8;
    localparam int DEEMPH_MSB   = 7;
    localparam int DEEMPH_LSB   = 4;
    localparam int RX_EN_BIT    = 2;
    localparam int RX_RATE_MSB  = 1;
    localparam int RX_RATE_LSB  = 0;

    // polarity and equalization field positions
    localparam int RX_INV_BIT   = 15;
    localparam int TX_INV_BIT   = 14;
    localparam int EQ_MSB       = 11;
    localparam int EQ_LSB       = 8;

    // spare bits that are stored and read back but drive nothing
    localparam int DRV_RSVD_HI_BIT = 15;
    localparam int DRV_RSVD_LO_BIT = 3;
    localparam int POL_RSVD_MSB    = 13;
    localparam int POL_RSVD_LSB    = 12;
    localparam int POL_LOW_MSB     = 7;
    localparam int POL_LOW_LSB     = 0;

    // lane rate codes; code 2'h3 is reserved and stored as written
    localparam logic [1:0] RATE_FULL    = 2'h0;
    localparam logic [1:0] RATE_HALF    = 2'h1;
    localparam logic [1:0] RATE_QUARTER = 2'h2;

    // equalizer codes; 4'h2..4'h7 reserved, 4'h8..4'hF adaptive with lower zero
    localparam logic [3:0] EQ_MAX_GAIN  = 4'h0;
    localparam logic [3:0] EQ_ADAPTIVE  = 4'h1;

    localparam int NUM_LANES = 4;

    typedef enum logic [1:0] {
        MODE_FOUR_LANE,
        MODE_TWO_LANE_10G,
        MODE_ONE_LANE_10G,
        MODE_ONE_G_KX
    } lslcr_mode_t;

    typedef struct packed {
        logic [2:0] output_amplitude_code;
        logic       signal_loss_detect_en;
        logic [1:0] tx_lane_rate_sel;
        logic [3:0] deemphasis_code;
        logic [1:0] rx_lane_rate_sel;
        logic       rx_output_invert;
        logic       tx_input_invert;
        logic [3:0] equalizer_code;
    } lslcr_lane_cfg_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  dev_addr;
        logic [15:0] reg_addr;
        logic [15:0] wdata;
    } lslcr_mgmt_req_t;

endpackage

// ==== rtl/lslcr_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

module lslcr_regs
(
    // clock and reset
    input  wire logic                                    clk_sys,
    input  wire logic                                    reset,
    // management register port
    input  wire lslcr_pkg::lslcr_mgmt_req_t              mgmt_req,
    output logic [15:0]                                  mgmt_rdata_q,
    output logic                                         mgmt_rvalid_q,
    // lane steering inputs
    input  wire logic [lslcr_pkg::NUM_LANES-1:0]         lane_select_mask,
    input  wire logic                                    powerdown_pin_n,
    input  wire logic                                    global_powerdown,
    input  wire lslcr_pkg::lslcr_mode_t                  lane_mode,
    // per-lane settings and the shared status overlay
    output lslcr_pkg::lslcr_lane_cfg_t [lslcr_pkg::NUM_LANES-1:0] lane_cfg_q,
    output logic [lslcr_pkg::NUM_LANES-1:0]              tx_lane_enable_q,
    output logic [lslcr_pkg::NUM_LANES-1:0]              rx_lane_enable_q,
    output logic [15:0]                                  status_overlay_q
);

    localparam int NL = lslcr_pkg::NUM_LANES;

    // per-lane fields live in lane_cfg_q; these hold the remaining bits
    logic [NL-1:0] tx_en_bit_q;
    logic [NL-1:0] rx_en_bit_q;
    logic [NL-1:0] drv_rsvd_hi_q;
    logic [NL-1:0] drv_rsvd_lo_q;
    logic [1:0]    pol_rsvd_hi_q [NL];
    logic [7:0]    pol_rsvd_lo_q [NL];
    logic [15:0]   driver_word   [NL];
    logic [15:0]   pol_eq_word   [NL];
    logic [15:0]   overlay_q;
    logic          dev_hit;
    logic          wr_driver;
    logic          wr_pol_eq;
    logic          wr_overlay;
    logic [NL-1:0] tx_mode_allow;
    logic [NL-1:0] rx_mode_allow;
    logic          powered;
    logic          sel_valid;
    logic [1:0]    sel_lane;
    logic [15:0]   rdata_d;

    // only our own management address is decoded; other devices fall through
    assign dev_hit    = mgmt_req.dev_addr == lslcr_pkg::DEV_ADDR;
    assign wr_driver  = mgmt_req.wr && dev_hit
                        && mgmt_req.reg_addr == lslcr_pkg::OFS_LANE_DRIVER;
    assign wr_pol_eq  = mgmt_req.wr && dev_hit
                        && mgmt_req.reg_addr == lslcr_pkg::OFS_LANE_POL_EQ;
    assign wr_overlay = mgmt_req.wr && dev_hit
                        && mgmt_req.reg_addr == lslcr_pkg::OFS_STATUS_OVERLAY;

    // field stores drive the lane outputs directly; a lane only takes a
    // write when its mask bit is set, so lanes may hold different settings
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < NL; i++)
        begin
            if (reset)
            begin
                // reset words come from the package so fields and readback agree
                lane_cfg_q[i].output_amplitude_code <=
                    lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::AMP_MSB:lslcr_pkg::AMP_LSB];
                lane_cfg_q[i].signal_loss_detect_en <=
                    lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::LOS_EN_BIT];
                lane_cfg_q[i].tx_lane_rate_sel <=
                    lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::TX_RATE_MSB:lslcr_pkg::TX_RATE_LSB];
                lane_cfg_q[i].deemphasis_code <=
                    lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::DEEMPH_MSB:lslcr_pkg::DEEMPH_LSB];
                lane_cfg_q[i].rx_lane_rate_sel <=
                    lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::RX_RATE_MSB:lslcr_pkg::RX_RATE_LSB];
                lane_cfg_q[i].rx_output_invert <=
                    lslcr_pkg::RST_LANE_POL_EQ[lslcr_pkg::RX_INV_BIT];
                lane_cfg_q[i].tx_input_invert <=
                    lslcr_pkg::RST_LANE_POL_EQ[lslcr_pkg::TX_INV_BIT];
                lane_cfg_q[i].equalizer_code <=
                    lslcr_pkg::RST_LANE_POL_EQ[lslcr_pkg::EQ_MSB:lslcr_pkg::EQ_LSB];
            end
            else
            begin
                // driver word fields
                if (wr_driver && lane_select_mask[i])
                begin
                    lane_cfg_q[i].output_amplitude_code <=
                        mgmt_req.wdata[lslcr_pkg::AMP_MSB:lslcr_pkg::AMP_LSB];
                    lane_cfg_q[i].signal_loss_detect_en <=
                        mgmt_req.wdata[lslcr_pkg::LOS_EN_BIT];
                    lane_cfg_q[i].tx_lane_rate_sel <=
                        mgmt_req.wdata[lslcr_pkg::TX_RATE_MSB:lslcr_pkg::TX_RATE_LSB];
                    lane_cfg_q[i].deemphasis_code <=
                        mgmt_req.wdata[lslcr_pkg::DEEMPH_MSB:lslcr_pkg::DEEMPH_LSB];
                    lane_cfg_q[i].rx_lane_rate_sel <=
                        mgmt_req.wdata[lslcr_pkg::RX_RATE_MSB:lslcr_pkg::RX_RATE_LSB];
                end
                // polarity and equalizer word fields
                if (wr_pol_eq && lane_select_mask[i])
                begin
                    lane_cfg_q[i].rx_output_invert <=
                        mgmt_req.wdata[lslcr_pkg::RX_INV_BIT];
                    lane_cfg_q[i].tx_input_invert <=
                        mgmt_req.wdata[lslcr_pkg::TX_INV_BIT];
                    lane_cfg_q[i].equalizer_code <=
                        mgmt_req.wdata[lslcr_pkg::EQ_MSB:lslcr_pkg::EQ_LSB];
                end
            end
        end
    end

    // stored enables and spare driver bits; forcing never touches these, so
    // a lane comes back with its own setting when powerdown or the mode lifts
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < NL; i++)
        begin
            if (reset)
            begin
                tx_en_bit_q[i]   <= lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::TX_EN_BIT];
                rx_en_bit_q[i]   <= lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::RX_EN_BIT];
                drv_rsvd_hi_q[i] <= lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::DRV_RSVD_HI_BIT];
                drv_rsvd_lo_q[i] <= lslcr_pkg::RST_LANE_DRIVER[lslcr_pkg::DRV_RSVD_LO_BIT];
            end
            else if (wr_driver && lane_select_mask[i])
            begin
                tx_en_bit_q[i]   <= mgmt_req.wdata[lslcr_pkg::TX_EN_BIT];
                rx_en_bit_q[i]   <= mgmt_req.wdata[lslcr_pkg::RX_EN_BIT];
                drv_rsvd_hi_q[i] <= mgmt_req.wdata[lslcr_pkg::DRV_RSVD_HI_BIT];
                drv_rsvd_lo_q[i] <= mgmt_req.wdata[lslcr_pkg::DRV_RSVD_LO_BIT];
            end
        end
    end

    // spare polarity bits are kept per lane too so they read back as written
    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < NL; i++)
        begin
            if (reset)
            begin
                pol_rsvd_hi_q[i] <=
                    lslcr_pkg::RST_LANE_POL_EQ[lslcr_pkg::POL_RSVD_MSB:lslcr_pkg::POL_RSVD_LSB];
                pol_rsvd_lo_q[i] <=
                    lslcr_pkg::RST_LANE_POL_EQ[lslcr_pkg::POL_LOW_MSB:lslcr_pkg::POL_LOW_LSB];
            end
            else if (wr_pol_eq && lane_select_mask[i])
            begin
                pol_rsvd_hi_q[i] <=
                    mgmt_req.wdata[lslcr_pkg::POL_RSVD_MSB:lslcr_pkg::POL_RSVD_LSB];
                pol_rsvd_lo_q[i] <=
                    mgmt_req.wdata[lslcr_pkg::POL_LOW_MSB:lslcr_pkg::POL_LOW_LSB];
            end
        end
    end

    // the overlay word is shared by all lanes and ignores the lane mask
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            overlay_q <= lslcr_pkg::RST_STATUS_OVERLAY;
        end
        else if (wr_overlay)
        begin
            overlay_q <= mgmt_req.wdata;
        end
    end

    assign status_overlay_q = overlay_q;

    // driver word readback is rebuilt from the field stores
    always_comb
    begin
        for (int i = 0; i < NL; i++)
        begin
            driver_word[i] = {drv_rsvd_hi_q[i],
                              lane_cfg_q[i].output_amplitude_code,
                              lane_cfg_q[i].signal_loss_detect_en,
                              tx_en_bit_q[i],
                              lane_cfg_q[i].tx_lane_rate_sel,
                              lane_cfg_q[i].deemphasis_code,
                              drv_rsvd_lo_q[i],
                              rx_en_bit_q[i],
                              lane_cfg_q[i].rx_lane_rate_sel};
        end
    end

    // polarity word readback, spare bits included
    always_comb
    begin
        for (int i = 0; i < NL; i++)
        begin
            pol_eq_word[i] = {lane_cfg_q[i].rx_output_invert,
                              lane_cfg_q[i].tx_input_invert,
                              pol_rsvd_hi_q[i],
                              lane_cfg_q[i].equalizer_code,
                              pol_rsvd_lo_q[i]};
        end
    end

    // transmit lanes that the lane-count mode leaves alive
    always_comb
    begin
        case (lane_mode)
            lslcr_pkg::MODE_TWO_LANE_10G: tx_mode_allow = 4'h3;
            lslcr_pkg::MODE_ONE_LANE_10G: tx_mode_allow = 4'h1;
            lslcr_pkg::MODE_ONE_G_KX:     tx_mode_allow = 4'h1;
            default:                      tx_mode_allow = 4'hF;
        endcase
    end

    // receive lanes that the lane-count mode leaves alive
    always_comb
    begin
        case (lane_mode)
            lslcr_pkg::MODE_TWO_LANE_10G: rx_mode_allow = 4'h3;
            lslcr_pkg::MODE_ONE_LANE_10G: rx_mode_allow = 4'h1;
            lslcr_pkg::MODE_ONE_G_KX:     rx_mode_allow = 4'h1;
            default:                      rx_mode_allow = 4'hF;
        endcase
    end

    // either powerdown source forces every lane off, whatever the mode
    assign powered = powerdown_pin_n && !global_powerdown;

    // forcing only gates the outputs; the stored enable keeps its value and
    // comes back when the powerdown or the narrow mode goes away
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tx_lane_enable_q <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < NL; i++)
            begin
                tx_lane_enable_q[i] <= tx_en_bit_q[i]
                                       && powered && tx_mode_allow[i];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rx_lane_enable_q <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < NL; i++)
            begin
                rx_lane_enable_q[i] <= rx_en_bit_q[i]
                                       && powered && rx_mode_allow[i];
            end
        end
    end

    // reads need a one-hot mask; any other mask reads lane fields as zero
    // rather than picking one of several selected lanes at random
    always_comb
    begin
        sel_valid = 1'b1;
        sel_lane  = 2'h0;
        case (lane_select_mask)
            4'h1:    sel_lane = 2'h0;
            4'h2:    sel_lane = 2'h1;
            4'h4:    sel_lane = 2'h2;
            4'h8:    sel_lane = 2'h3;
            default: sel_valid = 1'b0;
        endcase
    end

    // unmapped offsets and foreign device addresses read as zero
    always_comb
    begin
        rdata_d = 16'h0000;
        if (dev_hit)
        begin
            case (mgmt_req.reg_addr)
                lslcr_pkg::OFS_LANE_DRIVER:
                    rdata_d = sel_valid ? driver_word[sel_lane] : 16'h0000;
                lslcr_pkg::OFS_LANE_POL_EQ:
                    rdata_d = sel_valid ? pol_eq_word[sel_lane] : 16'h0000;
                lslcr_pkg::OFS_STATUS_OVERLAY:
                    rdata_d = overlay_q;
                default:
                    rdata_d = 16'h0000;
            endcase
        end
    end

    // one-cycle answer to every read strobe, mapped or not
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mgmt_rvalid_q <= 1'b0;
        end
        else
        begin
            mgmt_rvalid_q <= mgmt_req.rd;
        end
    end

    // read data holds until the next read so a slow host can pick it up late
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mgmt_rdata_q <= 16'h0000;
        end
        else if (mgmt_req.rd)
        begin
            mgmt_rdata_q <= rdata_d;
        end
    end

endmodule

`default_nettype wire

// ==== tb/ls_serdes_lane_control_regs_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ls_serdes_lane_control_regs_tb_top;
    logic                              clk_sys;
    logic                              reset;
    lslcr_pkg::lslcr_mgmt_req_t        req;
    logic [15:0]                       rdata;
    logic                              rvalid;
    logic [3:0]                        mask;
    logic                              pd_n;
    logic                              gpd;
    lslcr_pkg::lslcr_mode_t            mode;
    lslcr_pkg::lslcr_lane_cfg_t [3:0]  cfg;
    logic [3:0]                        tx_en;
    logic [3:0]                        rx_en;
    logic [15:0]                       ovl;
    logic [3:0]                        mode_exp [4] = '{4'hF, 4'h3, 4'h1, 4'h1};
    int                                mismatches = 0;
    int                                comparisons = 0;
    int                                cycles = 0;
    lslcr_regs u_dut (.clk_sys(clk_sys), .reset(reset), .mgmt_req(req), .mgmt_rdata_q(rdata),
        .mgmt_rvalid_q(rvalid), .lane_select_mask(mask), .powerdown_pin_n(pd_n),
        .global_powerdown(gpd), .lane_mode(mode), .lane_cfg_q(cfg), .tx_lane_enable_q(tx_en),
        .rx_lane_enable_q(rx_en), .status_overlay_q(ovl));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] d,
        input logic [3:0] m);
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, dev_addr: dev, reg_addr: a, wdata: d};
        mask = m;
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [4:0] dev, input logic [15:0] a, input logic [3:0] m,
        input logic [15:0] exp);
        @(negedge clk_sys);
        req = '{wr: 1'b0, rd: 1'b1, dev_addr: dev, reg_addr: a, wdata: 16'h0000};
        mask = m;
        @(negedge clk_sys);
        req.rd = 1'b0;
        chk("read valid", {15'h0000, rvalid}, 16'h0001);
        chk("read data", rdata, exp);
        @(negedge clk_sys);
        chk("read valid drop", {15'h0000, rvalid}, 16'h0000);
        chk("read data hold", rdata, exp);
    endtask
    task automatic settle_en(input logic [3:0] tx, input logic [3:0] rx);
        // enables are registered, so give the change two edges to land
        repeat (2) @(negedge clk_sys);
        chk("tx enables", {12'h000, tx_en}, {12'h000, tx});
        chk("rx enables", {12'h000, rx_en}, {12'h000, rx});
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    initial
    begin
        reset = 1'b1;
        req = '0;
        mask = 4'h1;
        pd_n = 1'b1;
        gpd = 1'b0;
        mode = lslcr_pkg::MODE_FOUR_LANE;
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rd(5'h1E, 16'h0007, 4'h1 << i, 16'hDC04);
            rd(5'h1E, 16'h0008, 4'h1 << i, 16'h000D);
        end
        rd(5'h1E, 16'h0009, 4'h0, 16'h0380);
        chk("overlay out", ovl, 16'h0380);
        $display("reset values done");
        for (int i = 0; i < 4; i++)
        begin
            mode = lslcr_pkg::lslcr_mode_t'(i[1:0]);
            settle_en(mode_exp[i], mode_exp[i]);
        end
        mode = lslcr_pkg::MODE_FOUR_LANE;
        pd_n = 1'b0;
        settle_en(4'h0, 4'h0);
        pd_n = 1'b1;
        gpd = 1'b1;
        settle_en(4'h0, 4'h0);
        gpd = 1'b0;
        $display("lane forcing done");
        wr(5'h1E, 16'h0007, 16'hA39E, 4'h5);
        settle_en(4'hA, 4'hF);
        chk("amplitude", {13'h0000, cfg[0].output_amplitude_code}, 16'h0002);
        chk("loss detect", {15'h0000, cfg[2].signal_loss_detect_en}, 16'h0000);
        chk("tx rate", {14'h0000, cfg[0].tx_lane_rate_sel}, 16'h0003);
        chk("deemphasis", {12'h000, cfg[2].deemphasis_code}, 16'h0009);
        chk("rx rate", {14'h0000, cfg[0].rx_lane_rate_sel}, 16'h0002);
        for (int i = 0; i < 4; i++)
            rd(5'h1E, 16'h0007, 4'h1 << i, i[0] ? 16'hDC04 : 16'hA39E);
        wr(5'h1E, 16'h0008, 16'hEF5A, 4'h6);
        @(negedge clk_sys);
        chk("rx invert", {15'h0000, cfg[1].rx_output_invert}, 16'h0001);
        chk("tx invert", {15'h0000, cfg[1].tx_input_invert}, 16'h0001);
        chk("equalizer", {12'h000, cfg[2].equalizer_code}, 16'h000F);
        rd(5'h1E, 16'h0008, 4'h2, 16'hEF5A);
        rd(5'h1E, 16'h0008, 4'h1, 16'h000D);
        rd(5'h1E, 16'h0007, 4'h3, 16'h0000);
        $display("lane writes done");
        wr(5'h1E, 16'h0009, 16'h1234, 4'h0);
        wr(5'h1D, 16'h0009, 16'hFFFF, 4'hF);
        rd(5'h1E, 16'h0009, 4'h0, 16'h1234);
        chk("overlay out", ovl, 16'h1234);
        rd(5'h1D, 16'h0007, 4'h1, 16'h0000);
        rd(5'h1E, 16'h000A, 4'h1, 16'h0000);
        $display("addressing done");
        give_verdict();
    end
endmodule
bind lslcr_regs lslcr_props u_props (.clk_sys(clk_sys), .reset(reset), .mgmt_req(mgmt_req),
    .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q),
    .lane_select_mask(lane_select_mask), .powerdown_pin_n(powerdown_pin_n),
    .global_powerdown(global_powerdown), .lane_mode(lane_mode), .lane_cfg_q(lane_cfg_q),
    .tx_lane_enable_q(tx_lane_enable_q), .rx_lane_enable_q(rx_lane_enable_q),
    .status_overlay_q(status_overlay_q));
`default_nettype wire

// ==== tb/lslcr_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module lslcr_props
(
    // clock and reset
    input wire logic                              clk_sys,
    input wire logic                              reset,
    // register port
    input wire lslcr_pkg::lslcr_mgmt_req_t        mgmt_req,
    input wire logic [15:0]                       mgmt_rdata_q,
    input wire logic                              mgmt_rvalid_q,
    // steering
    input wire logic [3:0]                        lane_select_mask,
    input wire logic                              powerdown_pin_n,
    input wire logic                              global_powerdown,
    input wire lslcr_pkg::lslcr_mode_t            lane_mode,
    // settings
    input wire lslcr_pkg::lslcr_lane_cfg_t [3:0]  lane_cfg_q,
    input wire logic [3:0]                        tx_lane_enable_q,
    input wire logic [3:0]                        rx_lane_enable_q,
    input wire logic [15:0]                       status_overlay_q
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic dev_ok;
    logic w7;
    assign dev_ok = mgmt_req.dev_addr == 5'h1E;
    assign w7 = mgmt_req.wr && dev_ok && mgmt_req.reg_addr == 16'h0007;
    read_answer_a: assert property (mgmt_req.rd |=> mgmt_rvalid_q)
        else $error("read got no answer");
    unmapped_zero_a: assert property (
        mgmt_req.rd && (!dev_ok || mgmt_req.reg_addr > 16'h0009
        || mgmt_req.reg_addr < 16'h0007) |=> mgmt_rdata_q == 16'h0000)
        else $error("foreign read not zero");
    mask_hold_a: assert property (w7 && !lane_select_mask[1] |=> $stable(lane_cfg_q[1]))
        else $error("masked lane changed");
    amp_write_a: assert property (
        w7 && lane_select_mask[0] |=>
        lane_cfg_q[0].output_amplitude_code == $past(mgmt_req.wdata[14:12]))
        else $error("amplitude not stored");
    pin_off_a: assert property (
        !powerdown_pin_n |=> (tx_lane_enable_q | rx_lane_enable_q) == 4'h0)
        else $error("lanes on with pin low");
    global_off_a: assert property (
        global_powerdown |=> (tx_lane_enable_q | rx_lane_enable_q) == 4'h0)
        else $error("lanes on in global powerdown");
    two_lane_a: assert property (
        lane_mode == lslcr_pkg::MODE_TWO_LANE_10G |=>
        tx_lane_enable_q[3:2] == 2'h0 && rx_lane_enable_q[3:2] == 2'h0)
        else $error("upper lanes on in two lane mode");
    one_lane_a: assert property (
        lane_mode inside {lslcr_pkg::MODE_ONE_LANE_10G, lslcr_pkg::MODE_ONE_G_KX} |=>
        (tx_lane_enable_q[3:1] | rx_lane_enable_q[3:1]) == 3'h0)
        else $error("extra lanes on in one lane mode");
    cover property (w7 && lane_select_mask == 4'h5);
    cover property (mgmt_req.rd && !dev_ok);
    cover property (lane_mode == lslcr_pkg::MODE_ONE_G_KX);
endmodule
`default_nettype wire
